/* pkg/asp_pkg.sv */
// Constants and types shared by the asynchronous serial port
package asp_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_CTRL3 = 3'h2;
  localparam logic [2:0] ADDR_STAT1 = 3'h3;
  localparam logic [2:0] ADDR_STAT2 = 3'h4;
  localparam logic [2:0] ADDR_DATA = 3'h5;
  localparam logic [2:0] ADDR_BAUD = 3'h6;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned C1_ENABLE = 6;
  localparam int unsigned C1_INVERT = 5;
  localparam int unsigned C1_NINE = 4;
  localparam int unsigned C1_PAR_EN = 1;
  localparam int unsigned C1_PAR_ODD = 0;
  localparam int unsigned C2_TBE_IE = 7;
  localparam int unsigned C2_TC_IE = 6;
  localparam int unsigned C2_RXF_IE = 5;
  localparam int unsigned C2_TX_EN = 3;
  localparam int unsigned C2_RX_EN = 2;
  localparam int unsigned C2_BREAK = 0;
  localparam int unsigned C3_RX_NINTH = 7;
  localparam int unsigned C3_TX_NINTH = 6;
  localparam int unsigned C3_OR_IE = 3;
  localparam int unsigned C3_NF_IE = 2;
  localparam int unsigned C3_FE_IE = 1;
  localparam int unsigned C3_PE_IE = 0;
  localparam int unsigned S1_TBE = 7;
  localparam int unsigned S1_TC = 6;
  localparam int unsigned S1_RXF = 5;
  localparam int unsigned S1_OR = 3;
  localparam int unsigned S1_NF = 2;
  localparam int unsigned S1_FE = 1;
  localparam int unsigned S1_PE = 0;
  localparam int unsigned S2_BREAK = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [6:0] CTRL3_RST = 7'h00;
  localparam logic [7:0] BAUD_RST = 8'h13;

  // ------------------------------------------------------------
  // Oversample phases and frame lengths
  // ------------------------------------------------------------
  localparam logic [4:0] PH_FIRST = 5'h01;
  localparam logic [4:0] PH_V1 = 5'h03;
  localparam logic [4:0] PH_V2 = 5'h05;
  localparam logic [4:0] PH_V3 = 5'h07;
  localparam logic [4:0] PH_D1 = 5'h08;
  localparam logic [4:0] PH_D2 = 5'h09;
  localparam logic [4:0] PH_D3 = 5'h0a;
  localparam logic [4:0] PH_LAST = 5'h10;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] STOP_IDX8 = 4'h9;
  localparam logic [3:0] STOP_IDX9 = 4'ha;
  localparam logic [3:0] FRAME_LEN8 = 4'ha;
  localparam logic [3:0] FRAME_LEN9 = 4'hb;

  typedef enum logic [1:0] {
    ASP_RX_HUNT = 2'b01,
    ASP_RX_RECV = 2'b10
  } asp_rx_state_t;

  typedef enum logic [1:0] {
    ASP_TX_IDLE = 2'b01,
    ASP_TX_SHIFT = 2'b10
  } asp_tx_state_t;

endpackage : asp_pkg

/* src/asp_top.sv */
// Asynchronous serial port: registers, receiver and interrupt requests
//
// Behaviour
// R1 - Invert every transmitted level when selected
// R2 - Set empty flag on buffer transfer, interrupt
// R3 - Complete flag when all empty, no break
// R4 - Eight or nine bits; ninth copies bit seven
// R5 - Move character to buffer, set full flag
// R6 - Sample line at sixteen per bit
// R7 - Realign after start and one-to-zero change
// R8 - Start edge is zero after three ones
// R9 - Verify start at phases three, five, seven
// R10 - Failed verification restarts the search
// R11 - Data bit is majority of 8-10
// R12 - Later start samples only raise noise
// R13 - Stop bit majority zero is framing error
// R14 - Framing error set with full flag
// R15 - Realign on valid falling edges mid-character
// R16 - Break clears buffer, ninth bit, sets flag
// R17 - Overrun keeps old character, drops new
// R18 - Error flags interrupt through own enables
// R19 - Interrupt lines are ORs of enabled flags
`timescale 1ns/1ps
module asp_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [asp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [asp_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [asp_pkg::DATA_W-1:0] rdata_o,
  // Serial pins
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  // Interrupt requests
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic err_irq_o
);
  import asp_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [6:0] ctrl3_q;
  logic [7:0] baud_q;
  logic [7:0] txbuf_q;
  logic [7:0] rxbuf_q;
  logic ninth_q;
  logic tbe_q;
  logic tc_q;
  logic rxf_q;
  logic or_q;
  logic nf_q;
  logic fe_q;
  logic pe_q;
  logic bkf_q;
  logic clr_arm_q;
  logic wr_data;
  logic rd_data;
  logic clr_rx;
  logic port_en;
  logic nine;

  assign wr_data = we_i && (addr_i == ADDR_DATA);
  assign rd_data = re_i && (addr_i == ADDR_DATA);
  assign clr_rx = rd_data && clr_arm_q;
  assign port_en = ctrl1_q[C1_ENABLE];
  assign nine = ctrl1_q[C1_NINE];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      ctrl3_q <= CTRL3_RST;
      baud_q <= BAUD_RST;
      txbuf_q <= 8'h00;
    end else if (we_i) begin
      if (addr_i == ADDR_CTRL1) begin
        ctrl1_q <= wdata_i;
      end else if (addr_i == ADDR_CTRL2) begin
        ctrl2_q <= wdata_i;
      end else if (addr_i == ADDR_CTRL3) begin
        ctrl3_q <= wdata_i[6:0];
      end else if (addr_i == ADDR_BAUD) begin
        baud_q <= wdata_i;
      end else if (addr_i == ADDR_DATA) begin
        txbuf_q <= wdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Oversample clock
  // ------------------------------------------------------------
  logic [7:0] div_q;
  logic tick_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q >= baud_q) begin
      div_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  logic tx_take;
  logic tx_busy;

  asp_tx u_tx (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_i(tick_q),
    .enable_i(port_en),
    .tx_en_i(ctrl2_q[C2_TX_EN]),
    .nine_i(nine),
    .invert_i(ctrl1_q[C1_INVERT]),
    .break_i(ctrl2_q[C2_BREAK]),
    .full_i(!tbe_q),
    .data_i({ctrl3_q[C3_TX_NINTH], txbuf_q}),
    .take_o(tx_take),
    .busy_o(tx_busy),
    .txd_o(txd_o),
    .txd_oe_o(txd_oe_o)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tbe_q <= 1'b1;
      tc_q <= 1'b1;
    end else begin
      if (tx_take) begin
        tbe_q <= 1'b1; // R2
      end else if (wr_data) begin
        tbe_q <= 1'b0;
      end
      tc_q <= tbe_q && !tx_take && !wr_data && !tx_busy &&
              !ctrl2_q[C2_BREAK]; // R3
    end
  end

  // ------------------------------------------------------------
  // Receiver data recovery
  // ------------------------------------------------------------
  asp_rx_state_t rx_st_q;
  logic [4:0] rt_q;
  logic [3:0] bit_q;
  logic [2:0] hist_q;
  logic [2:0] vote_q;
  logic [8:0] shreg_q;
  logic nf_acc_q;
  logic armed_q;
  logic prev_q;
  logic rx_on;
  logic [4:0] ph;
  logic [2:0] cur3;
  logic maj;
  logic dis;
  logic [3:0] stop_idx;
  logic in_data;
  logic edge_ok;
  logic tail;
  logic rx_done;

  assign rx_on = port_en && ctrl2_q[C2_RX_EN];
  assign ph = (rt_q == PH_LAST) ? PH_FIRST : rt_q + 5'h01; // R6
  assign cur3 = {vote_q[1:0], rxd_i};
  assign maj = (cur3[0] & cur3[1]) | (cur3[0] & cur3[2]) |
               (cur3[1] & cur3[2]);
  assign dis = (cur3 != 3'b000) && (cur3 != 3'b111);
  assign stop_idx = nine ? STOP_IDX9 : STOP_IDX8; // R4
  assign in_data = (bit_q != 4'h0);
  assign tail = (ph > PH_D3);
  assign edge_ok = armed_q && prev_q && !rxd_i && in_data &&
                   (tail || (ph < PH_D1 && ph != PH_FIRST));
  assign rx_done = (rx_st_q == ASP_RX_RECV) && tick_q && !edge_ok &&
                   (ph == PH_D3) && (bit_q == stop_idx);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_st_q <= ASP_RX_HUNT;
      rt_q <= PH_FIRST;
      bit_q <= 4'h0;
      hist_q <= 3'b000;
      vote_q <= 3'b000;
      shreg_q <= 9'h000;
      nf_acc_q <= 1'b0;
      armed_q <= 1'b0;
      prev_q <= 1'b1;
    end else if (!rx_on) begin
      rx_st_q <= ASP_RX_HUNT;
      hist_q <= 3'b000;
    end else if (tick_q) begin
      prev_q <= rxd_i;
      case (rx_st_q)
        ASP_RX_HUNT: begin
          hist_q <= {hist_q[1:0], rxd_i};
          if (!rxd_i && hist_q == 3'b111) begin
            rx_st_q <= ASP_RX_RECV; // R8
            rt_q <= PH_FIRST; // R7
            bit_q <= 4'h0;
            nf_acc_q <= 1'b0;
            armed_q <= 1'b0;
          end
        end
        ASP_RX_RECV: begin
          if (edge_ok) begin
            rt_q <= PH_FIRST; // R15
            armed_q <= 1'b0;
            if (tail) begin
              bit_q <= bit_q + 4'h1; // R7
            end
          end else begin
            rt_q <= ph;
            if (ph == PH_FIRST) begin
              bit_q <= bit_q + 4'h1;
            end
          end
          if (ph == PH_V1 || ph == PH_D1) begin
            vote_q <= {2'b00, rxd_i};
            if (ph == PH_D1) begin
              armed_q <= 1'b0;
            end
          end else if (ph == PH_V2 || ph == PH_V3 || ph == PH_D2) begin
            vote_q <= cur3;
          end
          if (ph == PH_V3 && !in_data) begin
            if (maj) begin
              rx_st_q <= ASP_RX_HUNT; // R10
              hist_q <= 3'b000;
            end else if (dis) begin
              nf_acc_q <= 1'b1; // R9
            end
          end
          if (ph == PH_D3 && !edge_ok) begin
            if (!in_data) begin
              if (cur3 != 3'b000) begin
                nf_acc_q <= 1'b1; // R12
              end
            end else if (bit_q != stop_idx) begin
              shreg_q <= {maj, shreg_q[8:1]}; // R11
              armed_q <= maj; // R7
              if (dis) begin
                nf_acc_q <= 1'b1; // R11
              end
            end else begin
              rx_st_q <= ASP_RX_HUNT;
              hist_q <= 3'b000;
            end
          end
        end
        default: begin
          rx_st_q <= ASP_RX_HUNT;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Character completion and status flags
  // ------------------------------------------------------------
  logic [8:0] rx9;
  logic stop_fe;
  logic is_brk;
  logic par_err;
  logic load_ok;

  assign rx9 = nine ? shreg_q : {shreg_q[8], shreg_q[8:1]}; // R4
  assign stop_fe = !maj; // R13
  assign is_brk = stop_fe && (rx9 == 9'h000);
  assign par_err = ctrl1_q[C1_PAR_EN] &&
                   ((nine ? ^rx9 : ^rx9[7:0]) != ctrl1_q[C1_PAR_ODD]);
  assign load_ok = !rxf_q || clr_rx;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rxbuf_q <= 8'h00;
      ninth_q <= 1'b0;
    end else if (rx_done && load_ok) begin
      rxbuf_q <= is_brk ? 8'h00 : rx9[7:0]; // R16
      ninth_q <= is_brk ? 1'b0 : rx9[8]; // R16
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rxf_q <= 1'b0;
      or_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      pe_q <= 1'b0;
      bkf_q <= 1'b0;
    end else begin
      if (clr_rx) begin
        rxf_q <= 1'b0;
        or_q <= 1'b0;
        nf_q <= 1'b0;
        fe_q <= 1'b0;
        pe_q <= 1'b0;
        bkf_q <= 1'b0;
      end
      if (rx_done && load_ok) begin
        rxf_q <= 1'b1; // R5
        fe_q <= stop_fe; // R14
        nf_q <= nf_acc_q || dis; // R13
        pe_q <= par_err && !is_brk;
        bkf_q <= is_brk; // R16
      end else if (rx_done) begin
        or_q <= 1'b1; // R17
      end
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clr_arm_q <= 1'b0;
    end else if (re_i && addr_i == ADDR_STAT1) begin
      clr_arm_q <= 1'b1;
    end else if (rd_data) begin
      clr_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!re_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == ADDR_CTRL1) begin
      rdata_o <= ctrl1_q;
    end else if (addr_i == ADDR_CTRL2) begin
      rdata_o <= ctrl2_q;
    end else if (addr_i == ADDR_CTRL3) begin
      rdata_o <= {ninth_q, ctrl3_q};
    end else if (addr_i == ADDR_STAT1) begin
      rdata_o <= {tbe_q, tc_q, rxf_q, 1'b0, or_q, nf_q, fe_q, pe_q};
    end else if (addr_i == ADDR_STAT2) begin
      rdata_o <= {6'h00, bkf_q, 1'b0};
    end else if (addr_i == ADDR_DATA) begin
      rdata_o <= rxbuf_q;
    end else if (addr_i == ADDR_BAUD) begin
      rdata_o <= baud_q;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Interrupt requests
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= (tbe_q && ctrl2_q[C2_TBE_IE]) ||
                  (tc_q && ctrl2_q[C2_TC_IE]); // R19
      rx_irq_o <= rxf_q && ctrl2_q[C2_RXF_IE]; // R5
      err_irq_o <= (or_q && ctrl3_q[C3_OR_IE]) ||
                   (nf_q && ctrl3_q[C3_NF_IE]) ||
                   (fe_q && ctrl3_q[C3_FE_IE]) ||
                   (pe_q && ctrl3_q[C3_PE_IE]); // R18
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence start_seen;
    rx_on && rx_st_q == ASP_RX_HUNT && tick_q && !rxd_i &&
    hist_q == 3'b111;
  endsequence

  sequence start_bad;
    rx_on && rx_st_q == ASP_RX_RECV && tick_q && ph == PH_V3 &&
    !in_data && maj;
  endsequence

  idle_level_a: assert property ( // R1
    !tx_busy && $past(!tx_busy) && $stable(ctrl1_q) |=>
    txd_o == !$past(ctrl1_q[C1_INVERT]))
    else $error("idle level polarity wrong");

  tbe_set_a: assert property (tx_take |=> tbe_q) // R2
    else $error("empty flag not set on transfer");

  tc_cause_a: assert property ( // R3
    tc_q |-> $past(tbe_q && !tx_busy && !ctrl2_q[C2_BREAK]))
    else $error("complete flag without idle transmitter");

  ninth_copy_a: assert property ( // R4
    rx_done && load_ok && !nine && !is_brk |=> ninth_q == rxbuf_q[7])
    else $error("ninth bit not a copy of bit seven");

  rx_full_a: assert property ( // R5
    rx_done && load_ok |=> rxf_q ##1 rx_irq_o == ctrl2_q[C2_RXF_IE])
    else $error("full flag or receive request missing");

  phase_tick_a: assert property ( // R6
    rx_st_q == ASP_RX_RECV && $changed(rt_q) |-> $past(tick_q))
    else $error("phase moved without sample tick");

  start_find_a: assert property ( // R8
    start_seen |=> rx_st_q == ASP_RX_RECV && rt_q == PH_FIRST)
    else $error("start edge not taken");

  verify_fail_a: assert property ( // R10
    start_bad |=> rx_st_q == ASP_RX_HUNT && hist_q == 3'b000)
    else $error("bad start bit not rejected");

  fe_with_full_a: assert property ( // R14
    rx_done && load_ok && stop_fe |=> fe_q && rxf_q)
    else $error("framing error not set with full flag");

  overrun_keep_a: assert property ( // R17
    rx_done && !load_ok |=> or_q && $stable(rxbuf_q))
    else $error("overrun did not keep old character");

  err_irq_a: assert property ( // R18
    or_q && ctrl3_q[C3_OR_IE] |=> err_irq_o)
    else $error("overrun request missing");

endmodule : asp_top

/* src/asp_tx.sv */
// Transmit shifter with polarity inversion and break generation
`timescale 1ns/1ps
module asp_tx (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic tx_en_i,
  input wire logic nine_i,
  input wire logic invert_i,
  input wire logic break_i,
  // Transmit buffer
  input wire logic full_i,
  input wire logic [8:0] data_i,
  output logic take_o,
  output logic busy_o,
  // Serial pin
  output logic txd_o,
  output logic txd_oe_o
);
  import asp_pkg::*;

  asp_tx_state_t st_q;
  logic [3:0] sub_q;
  logic [3:0] left_q;
  logic [10:0] shift_q;
  logic brk_q;
  logic bound;
  logic reload;
  logic load_brk;
  logic load_dat;

  // ------------------------------------------------------------
  // Bit timing and frame loading
  // ------------------------------------------------------------
  assign bound = tick_i && (sub_q == SUB_LAST);
  assign reload = (st_q == ASP_TX_IDLE) || (left_q == 4'h1);
  assign load_brk = enable_i && break_i;
  assign load_dat = enable_i && tx_en_i && full_i && !break_i &&
                    !(st_q == ASP_TX_SHIFT && brk_q);
  assign take_o = bound && reload && load_dat;
  assign busy_o = (st_q == ASP_TX_SHIFT);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sub_q <= 4'h0;
    end else if (tick_i) begin
      sub_q <= sub_q + 4'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= ASP_TX_IDLE;
      shift_q <= '1;
      left_q <= 4'h0;
      brk_q <= 1'b0;
    end else if (bound) begin
      if (reload && load_brk) begin
        st_q <= ASP_TX_SHIFT;
        shift_q <= '0;
        left_q <= nine_i ? FRAME_LEN9 : FRAME_LEN8;
        brk_q <= 1'b1;
      end else if (reload && load_dat) begin
        st_q <= ASP_TX_SHIFT;
        shift_q <= nine_i ? {1'b1, data_i, 1'b0}
                          : {2'b11, data_i[7:0], 1'b0};
        left_q <= nine_i ? FRAME_LEN9 : FRAME_LEN8;
        brk_q <= 1'b0;
      end else if (reload) begin
        st_q <= ASP_TX_IDLE;
        shift_q <= '1;
        left_q <= 4'h0;
        brk_q <= 1'b0;
      end else begin
        shift_q <= {1'b1, shift_q[10:1]};
        left_q <= left_q - 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
    end else begin
      txd_o <= shift_q[0] ^ invert_i; // R1
      txd_oe_o <= enable_i;
    end
  end

endmodule : asp_tx

/* verification/asp_remote.sv */
// Far-end serial device: frame sender and transmit line catcher
`timescale 1ns/1ps
module asp_remote (
  // Clock
  input wire logic mclk_i,
  // Serial lines
  input wire logic txd_i,
  output logic rxd_o
);
  // ------------------------------------------------------------
  // Sender, 16 mclk cycles per bit, idle high
  // ------------------------------------------------------------
  initial rxd_o = 1'b1;

  task automatic send(input logic [8:0] d, input int nb, input logic stop,
                      input int noisy);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : ((i <= nb) ? d[i-1] : stop);
      for (int s = 0; s < 16; s++) begin
        @(posedge mclk_i);
        rxd_o <= b ^ ((noisy >= 0) && (i - 1 == noisy) && (s == 8));
      end
    end
    @(posedge mclk_i);
    rxd_o <= 1'b1;
    repeat (40) @(posedge mclk_i);
  endtask : send

  // Low pulse too short to pass start verification
  task automatic glitch;
    @(posedge mclk_i);
    rxd_o <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rxd_o <= 1'b1;
    repeat (40) @(posedge mclk_i);
  endtask : glitch

  // ------------------------------------------------------------
  // Catcher: returns {stop, data} of one 8-bit frame
  // ------------------------------------------------------------
  task automatic catch(output logic [8:0] f, input logic inv);
    int n;
    n = 0;
    f = 9'h000;
    while ((txd_i ^ inv) !== 1'b0 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (8) @(posedge mclk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge mclk_i);
      f[i] = txd_i ^ inv;
    end
  endtask : catch
endmodule : asp_remote

/* verification/asp_top_bench.sv */
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module asp_top_bench;
  import asp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [7:0] rdata_o;
  logic rxd_i;
  logic txd_o, txd_oe_o, tx_irq_o, rx_irq_o, err_irq_o;
  int checks = 0;
  int n_fail = 0;
  logic [7:0] v;
  logic [8:0] f;
  logic [8:0] nine_vals [2] = '{9'h080, 9'h17f};

  always #12.5 mclk_i = ~mclk_i;

  asp_top u_asp_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
    .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
  asp_remote u_asp_remote (.mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // ------------------------------------------------------------
  // Register bus and helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    we_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge mclk_i);
    we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    re_i <= 1'b1; addr_i <= a;
    @(posedge mclk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic wait_rx;
    int n;
    n = 0;
    while (rx_irq_o !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK("rx_irq", 1'b1, rx_irq_o)
  endtask : wait_rx

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_STAT1, v); `CHK("stat1 reset", 8'hc0, v)
    rd(3'h7, v); `CHK("unmapped", 8'h00, v)
    `CHK("txd idle", 1'b1, txd_o)
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_CTRL2, 8'h24);
    wr(ADDR_CTRL3, 8'h0a);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_rx_noise;
    u_asp_remote.send(9'h0a5, 8, 1'b1, 3);
    wait_rx();
    rd(ADDR_STAT1, v); `CHK("rxf", 1'b1, v[S1_RXF])
    `CHK("nf", 1'b1, v[S1_NF])
    `CHK("err_irq nf off", 1'b0, err_irq_o)
    rd(ADDR_DATA, v); `CHK("data", 8'ha5, v)
    rd(ADDR_CTRL3, v); `CHK("ninth copy", 1'b1, v[7])
    repeat (3) @(posedge mclk_i);
    `CHK("rx_irq drop", 1'b0, rx_irq_o)
    $display("t_rx_noise done");
  endtask : t_rx_noise

  task automatic t_nine;
    wr(ADDR_CTRL1, 8'h50);
    foreach (nine_vals[i]) begin
      u_asp_remote.send(nine_vals[i], 9, 1'b1, -1);
      wait_rx();
      rd(ADDR_STAT1, v);
      rd(ADDR_DATA, v); `CHK("data9", nine_vals[i][7:0], v)
      rd(ADDR_CTRL3, v); `CHK("ninth", nine_vals[i][8], v[7])
    end
    wr(ADDR_CTRL1, 8'h40);
    $display("t_nine done");
  endtask : t_nine

  task automatic t_glitch;
    u_asp_remote.glitch();
    repeat (200) @(posedge mclk_i);
    `CHK("no frame", 1'b0, rx_irq_o)
    u_asp_remote.send(9'h03c, 8, 1'b1, -1);
    wait_rx();
    rd(ADDR_STAT1, v); `CHK("clean", 8'he0, v)
    rd(ADDR_DATA, v); `CHK("after glitch", 8'h3c, v)
    $display("t_glitch done");
  endtask : t_glitch

  task automatic t_frame_break;
    u_asp_remote.send(9'h0c3, 8, 1'b0, -1);
    wait_rx();
    `CHK("err_irq fe", 1'b1, err_irq_o)
    rd(ADDR_STAT1, v); `CHK("fe", 1'b1, v[S1_FE])
    rd(ADDR_DATA, v); `CHK("fe data", 8'hc3, v)
    u_asp_remote.send(9'h000, 8, 1'b0, -1);
    wait_rx();
    rd(ADDR_STAT2, v); `CHK("break", 1'b1, v[S2_BREAK])
    rd(ADDR_STAT1, v); `CHK("brk fe", 1'b1, v[S1_FE])
    rd(ADDR_DATA, v); `CHK("brk data", 8'h00, v)
    rd(ADDR_CTRL3, v); `CHK("brk ninth", 1'b0, v[7])
    $display("t_frame_break done");
  endtask : t_frame_break

  task automatic t_overrun;
    u_asp_remote.send(9'h011, 8, 1'b1, -1);
    u_asp_remote.send(9'h022, 8, 1'b1, -1);
    rd(ADDR_STAT1, v); `CHK("or", 1'b1, v[S1_OR])
    `CHK("err_irq or", 1'b1, err_irq_o)
    rd(ADDR_DATA, v); `CHK("kept", 8'h11, v)
    wr(ADDR_CTRL1, 8'h42);
    wr(ADDR_CTRL3, 8'h05);
    u_asp_remote.send(9'h001, 8, 1'b1, -1);
    wait_rx();
    `CHK("err_irq pe", 1'b1, err_irq_o)
    rd(ADDR_STAT1, v); `CHK("pe", 1'b1, v[S1_PE])
    rd(ADDR_DATA, v); `CHK("pe data", 8'h01, v)
    $display("t_overrun done");
  endtask : t_overrun

  task automatic t_tx;
    wr(ADDR_CTRL1, 8'h60);
    wr(ADDR_CTRL2, 8'hec);
    repeat (3) @(posedge mclk_i);
    `CHK("inv idle", 1'b0, txd_o)
    `CHK("oe", 1'b1, txd_oe_o)
    fork
      u_asp_remote.catch(f, 1'b1);
      begin
        wr(ADDR_DATA, 8'h5a);
        repeat (40) @(posedge mclk_i);
        rd(ADDR_STAT1, v); `CHK("tc busy", 1'b0, v[S1_TC])
      end
    join
    `CHK("tx frame", 9'h15a, f)
    repeat (40) @(posedge mclk_i);
    rd(ADDR_STAT1, v); `CHK("tbe tc", 2'b11, v[7:6])
    `CHK("tx_irq", 1'b1, tx_irq_o)
    $display("t_tx done");
  endtask : t_tx

  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rx_noise();
    t_nine();
    t_glitch();
    t_frame_break();
    t_overrun();
    t_tx();
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge mclk_i);
    n_fail++;
    wrap_up();
  end
endmodule : asp_top_bench
